/* File: bench/oag_pm_model.sv */
// program memory model answering pointer fetches
`timescale 1ns/10ps
module oag_pm_model (
   // clock
   input wire logic clk_sys,
   // fetch port
   input wire logic [15:0] pmAddr,
   input wire logic pmRead,
   output logic [7:0] pmData
);
   // ****************
   // memory behaviour
   // ****************
   // byte depends on all 16 address bits, so a stray high byte shows up
   // outside a fetch the data toggles: a frozen bus would hide a late sample
   logic [7:0] idleData;
   initial idleData = 8'h00;
   always @(posedge clk_sys) begin
      idleData <= ~idleData;
   end
   // read data follows the address within the fetch cycle
   assign pmData = (pmRead === 1'b1) ? (pmAddr[7:0] ^ pmAddr[15:8] ^ 8'h3c) : idleData;
endmodule : oag_pm_model

/* File: bench/testbench.sv */
// self-checking bench for operand address generation
`timescale 1ns/10ps
module testbench;
   import oag_pkg::*;
   // ****************
   // signals
   // ****************
   logic clk_sys, arst_n, clkEn, reqValid, ansValid, illegalOp, pcLoadValid;
   logic pmRead, regWrite, regRead, regHit, bankSel;
   oag_req_t req;
   oag_ans_t ans;
   logic [15:0] pcNext, pcLoad, pmAddr, seen;
   logic [7:0] pmData, regAddr, regWdata, regRdata, irqIn;
   int errors, samples_checked;
   typedef struct packed {
      oag_req_t r;
      logic [1:0] kind;
      oag_space_t sp;
      logic [15:0] exp;
   } oag_row_t;
   oag_row_t rows[16];
   logic [7:0] rwRegs[8];

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   oag_core i_oag_core (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn),
      .reqValid(reqValid), .req(req), .pcNext(pcNext), .ans(ans), .ansValid(ansValid),
      .illegalOp(illegalOp), .pcLoad(pcLoad), .pcLoadValid(pcLoadValid), .pmAddr(pmAddr),
      .pmRead(pmRead), .pmData(pmData), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit),
      .bankSel(bankSel), .irqIn(irqIn));
   oag_pm_model i_oag_pm_model (.clk_sys(clk_sys), .pmAddr(pmAddr), .pmRead(pmRead),
      .pmData(pmData));

   // ****************
   // tasks
   // ****************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chkv(input logic f, input logic [15:0] got, input logic [15:0] exp);
      chk({15'h0, f}, 16'h0001);
      chk(got, exp);
   endtask : chkv
   task automatic results();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   // k is the relative kind, and its bit 0 the wide flag for immediates
   function automatic oag_req_t mk(input oag_op_t o, input logic [15:0] f,
                                   input logic [15:0] b, input logic [7:0] w,
                                   input logic [2:0] k);
      mk = '{op: o, relKind: k, field: f, basePair: b, workReg: w, wideImm: k[0]};
   endfunction : mk
   task automatic issue(input oag_req_t r);
      int n;
      n = 0;
      // let an edge pass so reqValid never drops and rises in one step
      @(negedge clk_sys);
      req = r;
      reqValid = 1'b1;
      @(negedge clk_sys);
      reqValid = 1'b0;
      while (ansValid !== 1'b1 && pcLoadValid !== 1'b1 && illegalOp !== 1'b1 && n < 6) begin
         @(negedge clk_sys);
         n++;
      end
   endtask : issue
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clk_sys);
      regWrite = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk_sys);
      regRead = 1'b0;
      chk({8'h00, regRdata}, {8'h00, exp});
      chk({15'h0, regHit}, {15'h0, hit});
      @(negedge clk_sys);
   endtask : rd

   // pointer fetch watch
   always @(negedge clk_sys) begin
      if (pmRead === 1'b1) begin
         seen <= {seen[7:0], pmAddr[7:0]};
         chk({8'h00, pmAddr[15:8]}, 16'h0000);
      end
   end

   initial begin
      #200000;
      errors++;
      results();
   end

   // ****************
   // stimulus
   // ****************
   initial begin
      arst_n = 1'b0;
      clkEn = 1'b1;
      reqValid = 1'b0;
      req = '0;
      pcNext = 16'h0100;
      {regWrite, regRead, regAddr, regWdata, irqIn} = '0;
      errors = 0;
      samples_checked = 0;
      rwRegs = '{OFS_SYSTEM_FLAGS, OFS_WORKING_POINTER_ZERO, OFS_WORKING_POINTER_ONE,
         OFS_STACK_POINTER_HIGH, OFS_STACK_POINTER_LOW, OFS_INSTR_POINTER_HIGH,
         OFS_INSTR_POINTER_LOW, OFS_REGISTER_PAGE_POINTER};
      rows = '{
         '{mk(OAG_OP_REG_LOAD_IDX, 16'h0010, 16'h0, 8'h20, 3'h0), 2'h0, OAG_SP_REG, 16'h0030},
         '{mk(OAG_OP_REG_LOAD_IDX, 16'h00b0, 16'h0, 8'h20, 3'h0), 2'h0, OAG_SP_REG, 16'h01d0},
         '{mk(OAG_OP_REG_LOAD_IDX, 16'h00f0, 16'h0, 8'h20, 3'h0), 2'h0, OAG_SP_REG, 16'h0010},
         '{mk(OAG_OP_PM_LOAD_IDX_SHORT, 16'h0080, 16'h1000, 8'h0, 3'h0), 2'h0, OAG_SP_PROG,
           16'h0f80},
         '{mk(OAG_OP_EXT_LOAD_IDX_SHORT, 16'h007f, 16'h1000, 8'h0, 3'h0), 2'h0, OAG_SP_EXT,
           16'h107f},
         '{mk(OAG_OP_PM_LOAD_IDX_LONG, 16'h0200, 16'hff00, 8'h0, 3'h0), 2'h0, OAG_SP_PROG,
           16'h0100},
         '{mk(OAG_OP_EXT_LOAD_IDX_LONG, 16'h1111, 16'h1234, 8'h0, 3'h0), 2'h0, OAG_SP_EXT,
           16'h2345},
         '{mk(OAG_OP_PM_LOAD_DIRECT, 16'habcd, 16'h0, 8'h0, 3'h0), 2'h0, OAG_SP_PROG, 16'habcd},
         '{mk(OAG_OP_EXT_LOAD_DIRECT, 16'h5a5a, 16'h0, 8'h0, 3'h0), 2'h0, OAG_SP_EXT, 16'h5a5a},
         '{mk(OAG_OP_ABSOLUTE_JUMP, 16'h8000, 16'h0, 8'h0, 3'h0), 2'h1, OAG_SP_REG, 16'h8000},
         '{mk(OAG_OP_CALL_DIRECT, 16'h4321, 16'h0, 8'h0, 3'h0), 2'h1, OAG_SP_REG, 16'h4321},
         '{mk(OAG_OP_RELATIVE_JUMP, 16'h0080, 16'h0, 8'h0, 3'h0), 2'h1, OAG_SP_REG, 16'h0080},
         '{mk(OAG_OP_RELATIVE_JUMP, 16'h00ff, 16'h0, 8'h0, 3'h6), 2'h2, OAG_SP_REG, 16'h0000},
         '{mk(OAG_OP_IMMEDIATE, 16'hbeef, 16'h0, 8'h0, 3'h1), 2'h3, OAG_SP_REG, 16'hbeef},
         '{mk(OAG_OP_IMMEDIATE, 16'h0042, 16'h0, 8'h0, 3'h0), 2'h3, OAG_SP_REG, 16'h0042},
         '{mk(OAG_OP_INDIRECT_OTHER, 16'h0010, 16'h0, 8'h0, 3'h0), 2'h2, OAG_SP_REG, 16'h0000}};
      repeat (2) @(negedge clk_sys);
      arst_n = 1'b1;
      @(negedge clk_sys);
      foreach (rows[i]) begin
         issue(rows[i].r);
         case (rows[i].kind)
            2'h0: chkv(ansValid, ans.addr, rows[i].exp);
            2'h1: chkv(pcLoadValid, pcLoad, rows[i].exp);
            2'h2: chkv(illegalOp, 16'h0000, 16'h0000);
            default: chkv(ansValid, ans.immVal, rows[i].exp);
         endcase
         if (rows[i].kind == 2'h0) begin
            chk({14'h0, ans.space}, {14'h0, rows[i].sp});
         end
         if (rows[i].kind == 2'h3) begin
            chk({15'h0, ans.immWide}, {15'h0, rows[i].r.wideImm});
         end
      end
      pcNext = 16'hfff0;
      for (int k = 0; k < 6; k++) begin
         issue(mk(OAG_OP_RELATIVE_JUMP, 16'h0020 + k[15:0], 16'h0, 8'h0, k[2:0]));
         chkv(pcLoadValid, pcLoad, 16'h0010 + k[15:0]);
      end
      issue(mk(OAG_OP_CALL_INDIRECT, 16'h12ff, 16'h0, 8'h0, 3'h0));
      chkv(pcLoadValid, pcLoad, 16'hc33c);
      chk(seen, 16'hff00);
      // a held request with the enable low must not be taken
      @(negedge clk_sys);
      clkEn = 1'b0;
      req = mk(OAG_OP_ABSOLUTE_JUMP, 16'h1234, 16'h0, 8'h0, 3'h0);
      reqValid = 1'b1;
      repeat (3) begin
         @(negedge clk_sys);
         chk({15'h0, pcLoadValid}, 16'h0000);
      end
      reqValid = 1'b0;
      clkEn = 1'b1;
      foreach (rwRegs[i]) begin
         rd(rwRegs[i], 8'h00, 1'b1);
         wr(rwRegs[i], rwRegs[i] ^ 8'ha4);
         rd(rwRegs[i], rwRegs[i] ^ 8'ha4, 1'b1);
      end
      irqIn = 8'h96;
      wr(OFS_INTERRUPT_REQUEST, 8'h00);
      rd(OFS_INTERRUPT_REQUEST, 8'h96, 1'b1);
      wr(OFS_SYSTEM_FLAGS, 8'h00);
      rd(OFS_HOLE_A, 8'h00, 1'b0);
      rd(OFS_HOLE_B, 8'h00, 1'b0);
      chk({15'h0, bankSel}, 16'h0000);
      wr(OFS_SYSTEM_FLAGS, 8'h01);
      chk({15'h0, bankSel}, 16'h0001);
      rd(OFS_HOLE_A, 8'h00, 1'b1);
      rd(OFS_WORKING_POINTER_ONE, 8'hd7 ^ 8'ha4, 1'b1);
      // reset in mid-run clears the registers again
      arst_n = 1'b0;
      @(negedge clk_sys);
      arst_n = 1'b1;
      @(negedge clk_sys);
      chk({15'h0, bankSel}, 16'h0000);
      rd(OFS_WORKING_POINTER_ZERO, 8'h00, 1'b1);
      results();
   end
endmodule : testbench

/* File: design/oag_core.sv */
// operand and branch-target address generation with set 1 decode
`timescale 1ns/10ps
// What this block does
// - indexed: effective address is base plus offset
// - indexed never hits set 1 c0..ff
// - short memory offset is sign extended
// - register indexed: 8-bit base plus register
// - memory indexed: register pair plus offset
// - only register load indexes register file
// - program and external loads support indexing
// - direct: 16-bit address from instruction
// - direct jump or call loads pc
// - loads accept direct source or destination
// - indirect reads pointer pair, low 256 bytes
// - indirect accepted only for call
// - indirect pointer upper bits forced zero
// - relative: pc plus signed displacement
// - pc already points past current instruction
// - relative decoded for six branch kinds
// - immediate: operand field is the value
// - d0..d2 and e0..ff banked
// - interrupt request register is read-only
module oag_core
   import oag_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clkEn,
   // decode request
   input wire logic reqValid,
   input wire oag_req_t req,
   input wire logic [15:0] pcNext,
   // effective address answer
   output oag_ans_t ans,
   output logic ansValid,
   output logic illegalOp,
   output logic [15:0] pcLoad,
   output logic pcLoadValid,
   // program memory pointer fetch
   output logic [15:0] pmAddr,
   output logic pmRead,
   input wire logic [7:0] pmData,
   // set 1 register access
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic regHit,
   output logic bankSel,
   // interrupt request sources
   input wire logic [7:0] irqIn
);
   // ****************
   // set 1 decode
   // ****************
   logic [7:0] sysFlags;
   logic [7:0] wpZero;
   logic [7:0] wpOne;
   logic [7:0] spHigh;
   logic [7:0] spLow;
   logic [7:0] ipHigh;
   logic [7:0] ipLow;
   logic [7:0] irqReg;
   logic [7:0] pagePtr;
   logic [7:0] indexSum;
   logic [15:0] memOffset;
   logic [15:0] relSum;
   oag_state_t state;
   logic [7:0] ptrAddr;
   logic [7:0] destHigh;

   function automatic logic isBanked(input logic [7:0] a);
      isBanked = (a >= BANKA_LO && a <= BANKA_HI) || (a >= BANKB_LO);
   endfunction : isBanked

   function automatic logic isMapped(input logic [7:0] a, input logic bank);
      isMapped = (a >= SET1_LOW) &&
         !(isBanked(a) && !bank && (a == OFS_HOLE_A || a == OFS_HOLE_B));
   endfunction : isMapped

   // bank flag drives the banked decode
   assign bankSel = sysFlags[FLAG_BANK_BIT];

   // ****************
   // core register file
   // ****************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sysFlags <= RESET_REG;
         wpZero <= RESET_REG;
         wpOne <= RESET_REG;
         spHigh <= RESET_REG;
         spLow <= RESET_REG;
         ipHigh <= RESET_REG;
         ipLow <= RESET_REG;
         pagePtr <= RESET_REG;
      end else if (clkEn && regWrite) begin
         unique case (regAddr)
            OFS_SYSTEM_FLAGS: sysFlags <= regWdata;
            OFS_WORKING_POINTER_ZERO: wpZero <= regWdata;
            OFS_WORKING_POINTER_ONE: wpOne <= regWdata;
            OFS_STACK_POINTER_HIGH: spHigh <= regWdata;
            OFS_STACK_POINTER_LOW: spLow <= regWdata;
            OFS_INSTR_POINTER_HIGH: ipHigh <= regWdata;
            OFS_INSTR_POINTER_LOW: ipLow <= regWdata;
            OFS_REGISTER_PAGE_POINTER: pagePtr <= regWdata;
            default: ;
         endcase
      end
   end

   // request register follows sources, writes ignored
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irqReg <= RESET_REG;
      end else if (clkEn) begin
         irqReg <= irqIn;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         regRdata <= RESET_REG;
         regHit <= 1'b0;
      end else if (clkEn) begin
         regHit <= regRead && isMapped(regAddr, bankSel);
         unique case (regAddr)
            OFS_SYSTEM_FLAGS: regRdata <= sysFlags;
            OFS_WORKING_POINTER_ZERO: regRdata <= wpZero;
            OFS_WORKING_POINTER_ONE: regRdata <= wpOne;
            OFS_STACK_POINTER_HIGH: regRdata <= spHigh;
            OFS_STACK_POINTER_LOW: regRdata <= spLow;
            OFS_INSTR_POINTER_HIGH: regRdata <= ipHigh;
            OFS_INSTR_POINTER_LOW: regRdata <= ipLow;
            OFS_INTERRUPT_REQUEST: regRdata <= irqReg;
            OFS_REGISTER_PAGE_POINTER: regRdata <= pagePtr;
            default: regRdata <= RESET_REG;
         endcase
      end
   end

   // ****************
   // address arithmetic
   // ****************
   // 8-bit base plus working register, 8-bit result
   assign indexSum = req.field[7:0] + req.workReg;
   // short offsets sign extend to 16 bits
   assign memOffset = (req.op == OAG_OP_PM_LOAD_IDX_SHORT || req.op == OAG_OP_EXT_LOAD_IDX_SHORT)
      ? {{8{req.field[7]}}, req.field[7:0]} : req.field;
   // pcNext already past the current instruction; wraps
   assign relSum = pcNext + {{8{req.field[7]}}, req.field[7:0]};

   // ****************
   // answer
   // ****************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ans <= '0;
         ansValid <= 1'b0;
         illegalOp <= 1'b0;
         pcLoad <= 16'h0000;
         pcLoadValid <= 1'b0;
      end else if (clkEn) begin
         ansValid <= 1'b0;
         illegalOp <= 1'b0;
         pcLoadValid <= 1'b0;
         if (state == OAG_ST_PTR_LO) begin
            // high byte fetched first, low now
            pcLoad <= {destHigh, pmData};
            pcLoadValid <= 1'b1;
         end else if (reqValid && state == OAG_ST_IDLE) begin
            ans.immVal <= 16'h0000;
            ans.immWide <= 1'b0;
            unique case (req.op)
               OAG_OP_REG_LOAD_IDX: begin
                  // only register load indexes the register file
                  ans.space <= OAG_SP_REG;
                  // c0..ff redirected away from set 1
                  ans.addr <= {(indexSum >= SET1_LOW) ? 8'h01 : IDX_REDIRECT_BIT, indexSum};
                  ansValid <= 1'b1;
               end
               OAG_OP_PM_LOAD_IDX_SHORT, OAG_OP_PM_LOAD_IDX_LONG,
               OAG_OP_EXT_LOAD_IDX_SHORT, OAG_OP_EXT_LOAD_IDX_LONG: begin
                  ans.space <= (req.op == OAG_OP_PM_LOAD_IDX_SHORT ||
                     req.op == OAG_OP_PM_LOAD_IDX_LONG) ? OAG_SP_PROG : OAG_SP_EXT;
                  ans.addr <= req.basePair + memOffset;
                  ansValid <= 1'b1;
               end
               OAG_OP_PM_LOAD_DIRECT, OAG_OP_EXT_LOAD_DIRECT: begin
                  ans.space <= (req.op == OAG_OP_PM_LOAD_DIRECT) ? OAG_SP_PROG : OAG_SP_EXT;
                  ans.addr <= req.field;
                  ansValid <= 1'b1;
               end
               OAG_OP_ABSOLUTE_JUMP, OAG_OP_CALL_DIRECT: begin
                  pcLoad <= req.field;
                  pcLoadValid <= 1'b1;
               end
               OAG_OP_RELATIVE_JUMP: begin
                  if (req.relKind <= 3'd5) begin
                     pcLoad <= relSum;
                     pcLoadValid <= 1'b1;
                  end else begin
                     illegalOp <= 1'b1;
                  end
               end
               OAG_OP_IMMEDIATE: begin
                  ans.immVal <= req.wideImm ? req.field : {8'h00, req.field[7:0]};
                  ans.immWide <= req.wideImm;
                  ansValid <= 1'b1;
               end
               OAG_OP_CALL_INDIRECT: ;
               OAG_OP_INDIRECT_OTHER: illegalOp <= 1'b1;
               default: illegalOp <= (req.op != OAG_OP_NONE);
            endcase
         end
      end
   end

   // ****************
   // indirect pointer fetch
   // ****************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= OAG_ST_IDLE;
         ptrAddr <= 8'h00;
         destHigh <= 8'h00;
         pmAddr <= 16'h0000;
         pmRead <= 1'b0;
      end else if (clkEn) begin
         pmRead <= 1'b0;
         unique case (state)
            OAG_ST_IDLE: begin
               // pointer in low 256 bytes, upper zero
               if (reqValid && req.op == OAG_OP_CALL_INDIRECT) begin
                  ptrAddr <= req.field[7:0];
                  pmAddr <= {8'h00, req.field[7:0]};
                  pmRead <= 1'b1;
                  state <= OAG_ST_PTR_HI;
               end
            end
            OAG_ST_PTR_HI: begin
               // high byte at pointer, low at next
               destHigh <= pmData;
               pmAddr <= {8'h00, 8'(ptrAddr + 8'h01)};
               pmRead <= 1'b1;
               state <= OAG_ST_PTR_LO;
            end
            OAG_ST_PTR_LO: state <= OAG_ST_IDLE;
            default: state <= OAG_ST_IDLE;
         endcase
      end
   end

   // ****************
   // checks
   // ****************
   a_irq_readonly: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && regWrite && regAddr == OFS_INTERRUPT_REQUEST |=> irqReg == $past(irqIn))
      else $error("interrupt request took a write");
   a_indexed_no_set1: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ansValid && ans.space == OAG_SP_REG |-> ans.addr[15:8] != 8'h00 || ans.addr[7:0] < SET1_LOW)
      else $error("indexed access reached set 1");
   a_indirect_two_reads: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && state == OAG_ST_IDLE && reqValid && req.op == OAG_OP_CALL_INDIRECT
      ##1 clkEn[*2] |=> pcLoadValid)
      else $error("indirect call did not load pc");
   a_indirect_zero_hi: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pmRead |-> pmAddr[15:8] == 8'h00)
      else $error("pointer address above 256");
   a_direct_pc: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && reqValid && state == OAG_ST_IDLE && req.op == OAG_OP_ABSOLUTE_JUMP
      |=> pcLoadValid && pcLoad == $past(req.field))
      else $error("jump target not loaded");
   a_relative_sum: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && reqValid && state == OAG_ST_IDLE && req.op == OAG_OP_RELATIVE_JUMP
      && req.relKind <= 3'd5
      |=> pcLoadValid && pcLoad == $past(pcNext + {{8{req.field[7]}}, req.field[7:0]}))
      else $error("relative target wrong");
   a_indirect_only_call: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && reqValid && state == OAG_ST_IDLE && req.op == OAG_OP_INDIRECT_OTHER
      |=> illegalOp && !pcLoadValid)
      else $error("indirect accepted for non-call");
   a_bank_holes: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && regRead && !bankSel && (regAddr == OFS_HOLE_A || regAddr == OFS_HOLE_B)
      |=> !regHit)
      else $error("unmapped location answered");
   c_indirect: cover property (@(posedge clk_sys) disable iff (!arst_n)
      state == OAG_ST_PTR_LO && clkEn);
   c_rel: cover property (@(posedge clk_sys) disable iff (!arst_n)
      pcLoadValid && illegalOp == 1'b0);
   c_idx: cover property (@(posedge clk_sys) disable iff (!arst_n)
      ansValid && ans.space == OAG_SP_EXT);
endmodule : oag_core

/* File: design/oag_pkg.sv */
// package: constants and carriers for operand address generation
package oag_pkg;
   // ****************
   // set 1 register map
   // ****************
   localparam logic [7:0] SET1_LOW = 8'hc0;
   localparam logic [7:0] BANKA_LO = 8'hd0;
   localparam logic [7:0] BANKA_HI = 8'hd2;
   localparam logic [7:0] BANKB_LO = 8'he0;
   localparam logic [7:0] OFS_SYSTEM_FLAGS = 8'hd5;
   localparam logic [7:0] OFS_WORKING_POINTER_ZERO = 8'hd6;
   localparam logic [7:0] OFS_WORKING_POINTER_ONE = 8'hd7;
   localparam logic [7:0] OFS_STACK_POINTER_HIGH = 8'hd8;
   localparam logic [7:0] OFS_STACK_POINTER_LOW = 8'hd9;
   localparam logic [7:0] OFS_INSTR_POINTER_HIGH = 8'hda;
   localparam logic [7:0] OFS_INSTR_POINTER_LOW = 8'hdb;
   localparam logic [7:0] OFS_INTERRUPT_REQUEST = 8'hdc;
   localparam logic [7:0] OFS_REGISTER_PAGE_POINTER = 8'hdf;
   localparam logic [7:0] OFS_HOLE_A = 8'hfc;
   localparam logic [7:0] OFS_HOLE_B = 8'hfe;
   localparam int FLAG_BANK_BIT = 0;
   localparam logic [7:0] RESET_REG = 8'h00;
   // upper address byte for indexed results below c0; indexed hits in c0..ff take 01 instead
   localparam logic [7:0] IDX_REDIRECT_BIT = 8'h00;

   // ****************
   // operations
   // ****************
   typedef enum logic [3:0] {
      OAG_OP_NONE = 4'b0000,
      OAG_OP_REG_LOAD_IDX = 4'b0001,
      OAG_OP_PM_LOAD_IDX_SHORT = 4'b0010,
      OAG_OP_PM_LOAD_IDX_LONG = 4'b0011,
      OAG_OP_EXT_LOAD_IDX_SHORT = 4'b0100,
      OAG_OP_EXT_LOAD_IDX_LONG = 4'b0101,
      OAG_OP_PM_LOAD_DIRECT = 4'b0110,
      OAG_OP_EXT_LOAD_DIRECT = 4'b0111,
      OAG_OP_ABSOLUTE_JUMP = 4'b1000,
      OAG_OP_CALL_DIRECT = 4'b1001,
      OAG_OP_CALL_INDIRECT = 4'b1010,
      OAG_OP_RELATIVE_JUMP = 4'b1011,
      OAG_OP_IMMEDIATE = 4'b1100,
      OAG_OP_INDIRECT_OTHER = 4'b1101
   } oag_op_t;

   typedef enum logic [1:0] {
      OAG_SP_REG = 2'b00,
      OAG_SP_PROG = 2'b01,
      OAG_SP_EXT = 2'b10
   } oag_space_t;

   typedef enum logic [1:0] {
      OAG_ST_IDLE = 2'b00,
      OAG_ST_PTR_HI = 2'b01,
      OAG_ST_PTR_LO = 2'b10
   } oag_state_t;

   // request from decode
   typedef struct packed {
      oag_op_t op;
      logic [2:0] relKind;
      logic [15:0] field;
      logic [15:0] basePair;
      logic [7:0] workReg;
      logic wideImm;
   } oag_req_t;

   // effective address answer
   typedef struct packed {
      oag_space_t space;
      logic [15:0] addr;
      logic [15:0] immVal;
      logic immWide;
   } oag_ans_t;
endpackage : oag_pkg
